//--- verilog/aps_pkg.sv
// Package of constants and codes for the alarm and pump-down supervisor.
// Functional notes
// - Pump-down relay logic acts only when pump-down enabled and output logic is 1.
// - Demand on energises relay; off waits low pressure and delay; alarm drops it at once.
// - Pressure transmitter fault signals relay, closes valve, clears automatically.
// - Coil sensor fault signals relay only, valve untouched, clears automatically.
// - Discharge sensor fault alarms and signals only when monitoring is enabled.
// - Battery mode 1 shows code; 2 adds relay and close; 3 blinks, latches.
// - Pump-down failure blinks code, signals relay, needs manual reset.
// - Freeze mode 1 closes valve, auto reset; mode 2 blinks, signals, latches.
// - Low superheat mode 1 closes valve; mode 2 blinks, signals, latches.
// - Low pressure mode 1 closes valve; mode 2 blinks, signals, latches.
// - Display range error shows its code only, clearing by itself.
// - Show highest-priority alarm only; parameters return when all alarms clear.
// - Show three dashes at start-up and whenever display data is absent and no alarm is active.
// - Temporary display requests are refused while any alarm is active.
// - Temporary display shows identifier for one second, then the value.
// - After five minutes temporary display returns to the permanent selection.
package aps_pkg;
  localparam int CLOCK_HZ = 100_000_000;
  localparam int IDENT_TIME_MS = 1000;
  localparam int TEMP_TIME_MIN = 5;
  localparam int IDENT_CYCLES = CLOCK_HZ / 1000 * IDENT_TIME_MS;
  localparam longint TEMP_CYCLES = longint'(CLOCK_HZ) * 60 * TEMP_TIME_MIN;
  localparam int PD_DELAY_UNIT_MS = 1000;
  localparam int PD_DELAY_UNIT_CYCLES = CLOCK_HZ / 1000 * PD_DELAY_UNIT_MS;
  localparam int BLINK_TIME_MS = 500;
  localparam int BLINK_CYCLES = CLOCK_HZ / 1000 * BLINK_TIME_MS;

  localparam logic [1:0] OUT_LOGIC_PUMPDOWN = 2'h1;

  // Alarm indices, lowest index wins the display
  localparam int NUM_ALARMS = 9;
  localparam int AL_PRESSURE = 0;
  localparam int AL_COIL = 1;
  localparam int AL_DISCHARGE = 2;
  localparam int AL_BATTERY = 3;
  localparam int AL_PUMPDOWN = 4;
  localparam int AL_FREEZE = 5;
  localparam int AL_LOWSH = 6;
  localparam int AL_LOWPRESS = 7;
  localparam int AL_RANGE = 8;

  // Display symbol codes driven to the display unit
  typedef enum logic [3:0] {
    aps_code_value = 4'h0,
    aps_code_dashes = 4'h1,
    aps_code_ident = 4'h2,
    pressure_sensor_fault_code = 4'h3,
    coil_sensor_fault_code = 4'h4,
    discharge_sensor_fault_code = 4'h5,
    battery_fault_code = 4'h6,
    pumpdown_fail_code = 4'h7,
    freeze_alarm_code = 4'h8,
    low_superheat_code = 4'h9,
    low_pressure_code = 4'hA,
    display_range_error_code = 4'hB
  } aps_code_t;

  localparam aps_code_t ALARM_CODE [NUM_ALARMS] = '{
    pressure_sensor_fault_code, coil_sensor_fault_code, discharge_sensor_fault_code,
    battery_fault_code, pumpdown_fail_code, freeze_alarm_code, low_superheat_code,
    low_pressure_code, display_range_error_code};

  typedef enum logic [1:0] {
    aps_disp_perm = 2'h0,
    aps_disp_ident = 2'h1,
    aps_disp_temp = 2'h3
  } aps_disp_t;
endpackage

//--- verilog/aps_pumpdown.sv
// Pump-down relay sequencer.
`timescale 1ns/10ps
`default_nettype none
module aps_pumpdown
  import aps_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Asynchronous reset
  input wire logic active, // Pump-down behaviour selected
  input wire logic demand, // Synchronised cooling demand
  input wire logic below_cutout, // Suction pressure under cut-out
  input wire logic alarm_drop, // Any alarm forcing release
  input wire logic [7:0] delay_sec, // Pump-down delay in seconds
  output logic relay // Pump-down relay energised
);
  logic [31:0] tick_cnt;
  logic [7:0] sec_cnt;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h0;
      sec_cnt <= 8'h0;
    end else if (!relay || demand || !below_cutout) begin
      tick_cnt <= 32'h0;
      sec_cnt <= 8'h0;
    end else if (tick_cnt == 32'(PD_DELAY_UNIT_CYCLES - 1)) begin
      tick_cnt <= 32'h0;
      if (sec_cnt != 8'hFF) begin
        sec_cnt <= sec_cnt + 8'h1;
      end
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      relay <= 1'b0;
    end else if (!active) begin
      relay <= 1'b0;
    end else if (alarm_drop) begin
      relay <= 1'b0;
    end else if (demand) begin
      relay <= 1'b1;
    end else if (below_cutout && sec_cnt >= delay_sec) begin
      relay <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verilog/aps_supervisor.sv
// Alarm, pump-down and local display supervisor.
`timescale 1ns/10ps
`default_nettype none
module aps_supervisor
  import aps_pkg::*;
#(
  parameter longint TEMP_LIMIT = TEMP_CYCLES, // Temporary display time
  parameter int IDENT_LIMIT = IDENT_CYCLES, // Identifier display time
  parameter int BLINK_LIMIT = BLINK_CYCLES // Half period of blinking codes
)(
  input wire logic clock, // System clock
  input wire logic rst, // Asynchronous reset
  input wire logic cooling_demand, // Demand input pin, high at 24V
  input wire logic pressure_sensor_fault, // Transmitter signal invalid
  input wire logic coil_sensor_fault, // Coil-out sensor fault
  input wire logic discharge_sensor_fault, // Discharge sensor fault
  input wire logic battery_fault, // Battery fault
  input wire logic freeze_cond, // Freeze protection tripped
  input wire logic low_superheat_cond, // Superheat under 0,5K
  input wire logic low_pressure_cond, // Low pressure tripped
  input wire logic below_cutout, // Suction pressure under cut-out
  input wire logic pumpdown_fail_cond, // Pressure not reaching set-point
  input wire logic range_error, // Display data out of range
  input wire logic display_data_valid, // Data available for display
  input wire logic manual_reset, // Manual alarm reset pulse
  input wire logic temp_request, // Request temporary display pulse
  input wire logic [2:0] temp_select, // Value chosen for temporary display
  input wire logic [2:0] perm_select, // Permanent display selection
  input wire logic pump_down_enable, // Pump-down enable setting
  input wire logic [1:0] output_logic_select, // Output logic setting
  input wire logic [7:0] pump_down_delay, // Pump-down delay, seconds
  input wire logic [1:0] freeze_alarm_mode, // Freeze alarm mode
  input wire logic [1:0] low_superheat_alarm_mode, // Low superheat alarm mode
  input wire logic [1:0] low_pressure_alarm_mode, // Low pressure alarm mode
  input wire logic [1:0] battery_fault_mode, // Battery fault mode
  input wire logic discharge_sensor_monitor, // Monitor discharge sensor
  output logic alarm_relay, // Alarm relay signalling
  output logic valve_close, // Force valve fully closed
  output logic pump_down_relay, // Pump-down relay energised
  output logic [3:0] display_code, // Symbol shown on display
  output logic display_blink, // Shown code blinks
  output logic [2:0] display_select // Value or identifier selected
);
  // Input pins arrive asynchronously; two flops before use, except temp_request which is used directly
  localparam int NIN = 13;
  logic [NIN-1:0] in_raw, in_s1, in_s2;
  assign in_raw = {cooling_demand, pressure_sensor_fault, coil_sensor_fault,
                   discharge_sensor_fault, battery_fault, freeze_cond, low_superheat_cond,
                   low_pressure_cond, below_cutout, pumpdown_fail_cond, range_error,
                   display_data_valid, manual_reset};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      in_s1 <= in_raw;
      in_s2 <= in_s1;
    end
  end
  logic demand_s, press_f, coil_f, disch_f, batt_f, freeze_c, lowsh_c, lowp_c;
  logic cutout_s, pdfail_c, range_s, data_s, mreset_s;
  assign {demand_s, press_f, coil_f, disch_f, batt_f, freeze_c, lowsh_c, lowp_c,
          cutout_s, pdfail_c, range_s, data_s, mreset_s} = in_s2;

  logic mreset_d;
  logic mreset_pulse;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mreset_d <= 1'b0;
    end else begin
      mreset_d <= mreset_s;
    end
  end
  assign mreset_pulse = mreset_s && !mreset_d;

  logic pd_active;
  assign pd_active = pump_down_enable && (output_logic_select == OUT_LOGIC_PUMPDOWN);

  // Per-alarm raw condition, latching choice, relay, valve and pump-down effects
  logic [NUM_ALARMS-1:0] cond, latching, sig, close, pd_off, blink;
  always_comb begin
    cond = '0;
    latching = '0;
    sig = '0;
    close = '0;
    pd_off = '0;
    blink = '0;
    cond[AL_PRESSURE] = press_f;
    sig[AL_PRESSURE] = 1'b1;
    close[AL_PRESSURE] = 1'b1;
    cond[AL_COIL] = coil_f;
    sig[AL_COIL] = 1'b1;
    cond[AL_DISCHARGE] = disch_f && discharge_sensor_monitor;
    sig[AL_DISCHARGE] = 1'b1;
    cond[AL_BATTERY] = batt_f && (battery_fault_mode != 2'h0);
    sig[AL_BATTERY] = battery_fault_mode >= 2'h2;
    close[AL_BATTERY] = battery_fault_mode >= 2'h2;
    latching[AL_BATTERY] = battery_fault_mode == 2'h3;
    blink[AL_BATTERY] = battery_fault_mode == 2'h3;
    cond[AL_PUMPDOWN] = pdfail_c && pd_active;
    sig[AL_PUMPDOWN] = 1'b1;
    latching[AL_PUMPDOWN] = 1'b1;
    blink[AL_PUMPDOWN] = 1'b1;
    cond[AL_FREEZE] = freeze_c && (freeze_alarm_mode != 2'h0);
    close[AL_FREEZE] = freeze_alarm_mode == 2'h1;
    sig[AL_FREEZE] = freeze_alarm_mode == 2'h2;
    pd_off[AL_FREEZE] = freeze_alarm_mode == 2'h2;
    latching[AL_FREEZE] = freeze_alarm_mode == 2'h2;
    blink[AL_FREEZE] = freeze_alarm_mode == 2'h2;
    cond[AL_LOWSH] = lowsh_c && (low_superheat_alarm_mode != 2'h0);
    close[AL_LOWSH] = low_superheat_alarm_mode == 2'h1;
    sig[AL_LOWSH] = low_superheat_alarm_mode == 2'h2;
    pd_off[AL_LOWSH] = low_superheat_alarm_mode == 2'h2;
    latching[AL_LOWSH] = low_superheat_alarm_mode == 2'h2;
    blink[AL_LOWSH] = low_superheat_alarm_mode == 2'h2;
    cond[AL_LOWPRESS] = lowp_c && (low_pressure_alarm_mode != 2'h0);
    close[AL_LOWPRESS] = low_pressure_alarm_mode == 2'h1;
    sig[AL_LOWPRESS] = low_pressure_alarm_mode == 2'h2;
    pd_off[AL_LOWPRESS] = low_pressure_alarm_mode == 2'h2;
    latching[AL_LOWPRESS] = low_pressure_alarm_mode == 2'h2;
    blink[AL_LOWPRESS] = low_pressure_alarm_mode == 2'h2;
    cond[AL_RANGE] = range_s;
  end

  // Manual-reset alarms stay latched until reset with the cause gone;
  // a condition still present at reset keeps the latch (set wins)
  logic [NUM_ALARMS-1:0] held;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ALARMS; gi++) begin : g_latch
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          held[gi] <= 1'b0;
        end else if (cond[gi] && latching[gi]) begin
          held[gi] <= 1'b1;
        end else if (mreset_pulse || !latching[gi]) begin
          held[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  logic [NUM_ALARMS-1:0] active_al;
  assign active_al = cond | held;
  logic any_alarm;
  // Range error is an indication only and does not count as an alarm condition
  assign any_alarm = |(active_al & ~(NUM_ALARMS'(1) << AL_RANGE));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_relay <= 1'b0;
      valve_close <= 1'b0;
    end else begin
      alarm_relay <= |(active_al & sig);
      valve_close <= |(active_al & close);
    end
  end

  aps_pumpdown u_pumpdown (
    .clock(clock),
    .rst(rst),
    .active(pd_active),
    .demand(demand_s),
    .below_cutout(cutout_s),
    .alarm_drop(any_alarm || |(active_al & pd_off)),
    .delay_sec(pump_down_delay),
    .relay(pump_down_relay)
  );

  // Highest-priority active alarm: lowest index
  logic [3:0] top_idx;
  logic top_any;
  always_comb begin
    top_idx = 4'h0;
    top_any = 1'b0;
    for (int i = NUM_ALARMS - 1; i >= 0; i--) begin
      if (active_al[i]) begin
        top_idx = 4'(i);
        top_any = 1'b1;
      end
    end
  end

  // Temporary display sequencer
  aps_disp_t disp_state;
  logic [38:0] disp_cnt;
  logic [2:0] temp_sel_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      disp_state <= aps_disp_perm;
      disp_cnt <= '0;
      temp_sel_q <= 3'h0;
    end else begin
      unique case (disp_state)
        aps_disp_perm: begin
          disp_cnt <= '0;
          if (temp_request && !top_any) begin
            disp_state <= aps_disp_ident;
            temp_sel_q <= temp_select;
          end
        end
        aps_disp_ident: begin
          if (disp_cnt == 39'(IDENT_LIMIT - 1)) begin
            disp_state <= aps_disp_temp;
            disp_cnt <= '0;
          end else begin
            disp_cnt <= disp_cnt + 39'h1;
          end
        end
        aps_disp_temp: begin
          if (disp_cnt == 39'(TEMP_LIMIT - 1)) begin
            disp_state <= aps_disp_perm;
          end else begin
            disp_cnt <= disp_cnt + 39'h1;
          end
        end
      endcase
    end
  end

  // Blink phase runs freely; blinking codes share one rate
  logic [31:0] blink_cnt;
  logic blink_phase;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blink_cnt <= 32'h0;
      blink_phase <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_LIMIT - 1)) begin
      blink_cnt <= 32'h0;
      blink_phase <= !blink_phase;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  logic [3:0] next_code;
  logic [2:0] next_select;
  logic next_blink;
  always_comb begin
    next_code = aps_code_value;
    next_select = perm_select;
    next_blink = 1'b0;
    if (top_any) begin
      next_code = ALARM_CODE[top_idx];
      next_blink = blink[top_idx] && blink_phase;
    end else if (!data_s) begin
      next_code = aps_code_dashes;
    end else if (disp_state == aps_disp_ident) begin
      next_code = aps_code_ident;
      next_select = temp_sel_q;
    end else if (disp_state == aps_disp_temp) begin
      next_select = temp_sel_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      display_code <= aps_code_dashes;
      display_select <= 3'h0;
      display_blink <= 1'b0;
    end else begin
      display_code <= next_code;
      display_select <= next_select;
      display_blink <= next_blink;
    end
  end
endmodule
`default_nettype wire

//--- verification/aps_plant_model.sv
// Far-side model: demand pin and suction pressure response.
`timescale 1ns/10ps
`default_nettype none
module aps_plant_model #(
  parameter int LAG = 10 // Cycles for pressure to fall
)(
  input wire logic clock, // System clock
  input wire logic demand_req, // Wish for cooling
  output logic cooling_demand, // Demand pin, high at 24V
  output logic below_cutout // Suction under cut-out
);
  int cnt = 0;
  assign cooling_demand = demand_req;
  // Pressure decays over time, so the relay must wait for it
  always_ff @(posedge clock) begin
    if (cooling_demand) cnt <= 0;
    else if (cnt < LAG) cnt <= cnt + 1;
  end
  assign below_cutout = !cooling_demand && cnt >= LAG;
endmodule
`default_nettype wire

//--- verification/aps_supervisor_checker.sv
// Concurrent checks on the supervisor ports.
`timescale 1ns/10ps
`default_nettype none
module aps_supervisor_checker
  import aps_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic cooling_demand, // Demand
  input wire logic pressure_sensor_fault, // Fault
  input wire logic coil_sensor_fault, // Fault
  input wire logic discharge_sensor_fault, // Fault
  input wire logic battery_fault, // Fault
  input wire logic freeze_cond, // Trip
  input wire logic low_superheat_cond, // Trip
  input wire logic low_pressure_cond, // Trip
  input wire logic pumpdown_fail_cond, // Trip
  input wire logic temp_request, // Request
  input wire logic [2:0] temp_select, // Selection
  input wire logic pump_down_enable, // Setting
  input wire logic [1:0] output_logic_select, // Setting
  input wire logic alarm_relay, // Output
  input wire logic valve_close, // Output
  input wire logic pump_down_relay, // Output
  input wire logic [3:0] display_code, // Output
  input wire logic display_blink, // Output
  input wire logic [2:0] display_select // Output
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire quiet = ~|{pressure_sensor_fault, coil_sensor_fault, discharge_sensor_fault,
    battery_fault, freeze_cond, low_superheat_cond, low_pressure_cond,
    pumpdown_fail_cond, alarm_relay, valve_close};
  wire is_ident = display_code == aps_code_ident;
  sequence ident_phase;
    is_ident[*8];
  endsequence
  sequence pd_cause;
    (pump_down_enable && output_logic_select == 2'h1 && cooling_demand && quiet)[*4];
  endsequence
  a_reset_dashes: assert property ($fell(rst) |-> display_code == aps_code_dashes)
    else $error("no dashes after reset");
  a_temp_refused: assert property ((temp_request && display_code > 4'h2) |=> !is_ident)
    else $error("temporary display taken during alarm");
  a_ident_time: assert property ($rose(is_ident) |-> ident_phase ##[1:30]
    display_code == aps_code_value) else $error("identifier phase wrong");
  a_temp_select: assert property ($rose(is_ident) |-> display_select == $past(temp_select))
    else $error("identifier of wrong value");
  a_demand_pd: assert property (pd_cause |-> pump_down_relay)
    else $error("pump-down relay not energised");
  a_pd_inactive: assert property ((!(pump_down_enable && output_logic_select == 2'h1))[*4]
    |-> !pump_down_relay) else $error("pump-down relay while inactive");
  a_alarm_pd_drop: assert property ($rose(alarm_relay) |-> ##[0:1] !pump_down_relay)
    else $error("relay kept during alarm");
  a_pressure_close: assert property (pressure_sensor_fault[*4] |-> alarm_relay && valve_close)
    else $error("pressure fault not acted on");
  a_coil_relay: assert property (coil_sensor_fault[*4] |-> alarm_relay)
    else $error("coil fault not signalled");
  a_blink_alarm: assert property (display_blink |-> display_code > 4'h2)
    else $error("blinking without alarm code");
endmodule
bind aps_supervisor aps_supervisor_checker i_chk (.*);
`default_nettype wire

//--- verification/test_aps_supervisor.sv
// Self-checking bench for the alarm and pump-down supervisor.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module test_aps_supervisor import aps_pkg::*;;
  logic clock = 0, rst = 1, demand_req = 0, cooling_demand, below_cutout;
  logic manual_reset = 0, temp_request = 0, valid = 0, pde = 0, mon = 1, chk = 0;
  logic alarm_relay, valve_close, pump_down_relay, display_blink;
  logic [8:0] c = '0;
  logic [2:0] ts = 0, ps = 0, display_select;
  logic [1:0] ols = 0, m = 0, bm = 0;
  logic [3:0] display_code;
  logic [10:0] q[$];
  logic [10:0] e;
  // Row nibbles: condition, mode, {latch, relay, valve, pump-down}, code
  logic [15:0] rows [14] = '{16'h0163, 16'h1144, 16'h2145, 16'h3106, 16'h3266, 16'h33E6,
    16'h41C7, 16'h5128, 16'h52C8, 16'h6129, 16'h62C9, 16'h712A, 16'h72CA, 16'h811B};
  // Active setting last, so the pump-down steps below start energised
  logic [2:0] pdtab [5] = '{3'b001, 3'b110, 3'b100, 3'b111, 3'b101};
  int n_errors = 0, samples_checked = 0;
  aps_supervisor #(.TEMP_LIMIT(200), .IDENT_LIMIT(20), .BLINK_LIMIT(4)) i_dut (
    .clock(clock), .rst(rst), .cooling_demand(cooling_demand),
    .pressure_sensor_fault(c[0]), .coil_sensor_fault(c[1]), .discharge_sensor_fault(c[2]),
    .battery_fault(c[3]), .pumpdown_fail_cond(c[4]), .freeze_cond(c[5]),
    .low_superheat_cond(c[6]), .low_pressure_cond(c[7]), .range_error(c[8]),
    .below_cutout(below_cutout), .display_data_valid(valid), .manual_reset(manual_reset),
    .temp_request(temp_request), .temp_select(ts), .perm_select(ps),
    .pump_down_enable(pde), .output_logic_select(ols), .pump_down_delay(8'h00),
    .freeze_alarm_mode(m), .low_superheat_alarm_mode(m), .low_pressure_alarm_mode(m),
    .battery_fault_mode(bm), .discharge_sensor_monitor(mon), .alarm_relay(alarm_relay),
    .valve_close(valve_close), .pump_down_relay(pump_down_relay),
    .display_code(display_code), .display_blink(display_blink),
    .display_select(display_select));
  aps_plant_model #(.LAG(10)) i_plant (.clock(clock), .demand_req(demand_req),
    .cooling_demand(cooling_demand), .below_cutout(below_cutout));
  initial forever #5 clock = ~clock;
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Top bit of a note says whether the display selection is compared
  task automatic ex(logic [10:0] v);
    q.push_back(v);
    chk = 1;
    cyc(1);
    chk = 0;
  endtask
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) if (chk) begin
    e = q.pop_front();
    `CHK({alarm_relay, valve_close, pump_down_relay, display_code,
      e[10] ? display_select : 3'h0}, e[9:0])
  end
  initial begin
    repeat (4000) @(posedge clock);
    n_errors++;
    final_report();
  end
  initial begin
    void'($urandom(41462));
    ps = 3'($urandom);
    ts = ps ^ 3'($urandom | 1);
    cyc(16);
    rst = 0;
    ex({1'b0, 3'b000, 4'h1, 3'h0});
    valid = 1;
    demand_req = 1;
    for (int i = 0; i < 5; i++) begin
      {pde, ols} = pdtab[i];
      cyc(6);
      ex({1'b1, 2'b00, i == 4, 4'h0, ps});
    end
    demand_req = 0;
    cyc(6);
    ex({1'b1, 3'b001, 4'h0, ps});
    cyc(20);
    ex({1'b1, 3'b000, 4'h0, ps});
    demand_req = 1;
    cyc(6);
    foreach (rows[k]) begin
      {m, bm} = {2{rows[k][9:8]}};
      c[rows[k][15:12]] = 1;
      cyc(6);
      ex({1'b0, rows[k][6:4], rows[k][3:0], 3'h0});
      temp_request = 1;
      cyc(1);
      temp_request = 0;
      cyc(3);
      ex({1'b0, rows[k][6:4], rows[k][3:0], 3'h0});
      c = '0;
      cyc(6);
      if (rows[k][7]) ex({1'b0, rows[k][6:5], 1'b0, rows[k][3:0], 3'h0});
      manual_reset = 1;
      cyc(4);
      manual_reset = 0;
      cyc(6);
      ex({1'b1, 3'b001, 4'h0, ps});
    end
    c = 9'h006;
    cyc(6);
    ex({1'b0, 3'b100, 4'h4, 3'h0});
    c = 9'h004;
    cyc(6);
    ex({1'b0, 3'b100, 4'h5, 3'h0});
    mon = 0;
    cyc(6);
    ex({1'b1, 3'b001, 4'h0, ps});
    c = '0;
    mon = 1;
    valid = 0;
    cyc(6);
    ex({1'b0, 3'b001, 4'h1, 3'h0});
    valid = 1;
    cyc(6);
    temp_request = 1;
    cyc(1);
    temp_request = 0;
    cyc(8);
    ex({1'b1, 3'b001, 4'h2, ts});
    cyc(14);
    ex({1'b1, 3'b001, 4'h0, ts});
    cyc(180);
    ex({1'b1, 3'b001, 4'h0, ts});
    cyc(20);
    ex({1'b1, 3'b001, 4'h0, ps});
    final_report();
  end
endmodule
`default_nettype wire
